// File: fup_consts.svh
`ifndef FUP_CONSTS_SVH
`define FUP_CONSTS_SVH

`define FUP_CLK_PERIOD_NS 20
`define FUP_OP_UDPD_ENTER 8'h79
`define FUP_OP_CFG_B0 8'h3d
`define FUP_OP_CFG_B1 8'h2a
`define FUP_OP_CFG_B2 8'h80
`define FUP_OP_CFG_512 8'ha6
`define FUP_OP_CFG_528 8'ha7
`define FUP_CFG_LEN 3'h4
`define FUP_PAGE_BINARY 10'h200
`define FUP_PAGE_EXTRA 10'h010
`define FUP_SEL512_DEFAULT 1'b0
`define FUP_UDPD_ENTRY_TIME_NS 3000
`define FUP_EXIT_PULSE_LOW_TIME_NS 20
`define FUP_UDPD_EXIT_RECOVERY_TIME_NS 100000
`define FUP_CONFIG_PROGRAM_TIME_NS 50000000
`define FUP_UDPD_ENTRY_CYC (`FUP_UDPD_ENTRY_TIME_NS / `FUP_CLK_PERIOD_NS)
`define FUP_EXIT_LOW_CYC \
  ((`FUP_EXIT_PULSE_LOW_TIME_NS + `FUP_CLK_PERIOD_NS - 1) / `FUP_CLK_PERIOD_NS)
`define FUP_EXIT_RECOVERY_CYC (`FUP_UDPD_EXIT_RECOVERY_TIME_NS / `FUP_CLK_PERIOD_NS)
`define FUP_CONFIG_PROG_CYC (`FUP_CONFIG_PROGRAM_TIME_NS / `FUP_CLK_PERIOD_NS)

`endif

// File: fup_pkg.sv
`default_nettype none
package fup_pkg;
  typedef logic [7:0] fup_byte_t;
  typedef logic [21:0] fup_count_t;
  typedef enum logic [4:0] {
    ST_STANDBY = 5'b00001,
    ST_ENTER = 5'b00010,
    ST_UDPD = 5'b00100,
    ST_EXIT = 5'b01000,
    ST_PROG = 5'b10000
  } fup_state_e;
endpackage : fup_pkg
`default_nettype wire

// File: fup_shifter.sv
`default_nettype none
`include "fup_consts.svh"
module fup_shifter
  import fup_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic byte_strobe,
  output fup_byte_t byte_data,
  output logic [2:0] byte_idx,
  output logic [2:0] bit_cnt
);
  logic sck_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  fup_byte_t shift_reg;
  logic sck_rise;

  // Data is sampled on the rising serial clock edge while selected.
  assign sck_rise = sck & ~sck_prev_reg & ~cs_n;
  assign bit_cnt = bit_cnt_reg;
  assign byte_data = {shift_reg[6:0], si};
  assign byte_strobe = sck_rise && (bit_cnt_reg == 3'h7);
  assign byte_idx = byte_cnt_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      sck_prev_reg <= 1'b0;
    else
      sck_prev_reg <= sck;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn || cs_n)
    begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
    end
    else if (sck_rise)
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= {shift_reg[6:0], si};
    end
  end

  // Byte index saturates once past the longest sequence of interest.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || cs_n)
      byte_cnt_reg <= 3'h0;
    else if (byte_strobe && byte_cnt_reg != `FUP_CFG_LEN)
      byte_cnt_reg <= byte_cnt_reg + 3'h1;
  end
endmodule : fup_shifter
`default_nettype wire

// File: fup_power_cfg.sv
// Functional notes
// - Entering power-down shuts circuitry, loses buffers.
// - Power-down ignores every command, status included.
// - Opcode 79h then select rise enters power-down.
// - Bits after entry opcode are discarded.
// - Short or off-boundary frame aborts entry.
// - Power-up always starts in standby.
// - Entry ignored while self-timed operation runs.
// - Dummy byte during wake pulse is ignored.
// - Standby returns within exit recovery time.
// - Frames started during recovery are ignored.
// - Buffers are undefined after leaving power-down.
// - Standard size adds sixteen bytes per page.
// - Size switches either way, any number times.
// - Size is nonvolatile; factory default 528 bytes.
// - Sequence 3D 2A 80 A6 selects 512 bytes.
// - Sequence 3D 2A 80 A7 selects 528 bytes.
// - Size programming starts at select rise.
// - Busy is reported during size programming.
// - New size applies when programming completes.
// - Ready flag low while busy, high after.
// - Size flag reports current page size.
`default_nettype none
`include "fup_consts.svh"
module fup_power_cfg
  import fup_pkg::*;
#(
  parameter int unsigned EXIT_RECOVERY_CYC = `FUP_EXIT_RECOVERY_CYC,
  parameter int unsigned CONFIG_PROG_CYC = `FUP_CONFIG_PROG_CYC
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic op_busy,
  input wire logic nv_sel512,
  output logic power_down,
  output logic buffers_lost,
  output logic buffers_undefined,
  output logic rdy_busy,
  output logic size_sel512,
  output logic [9:0] page_bytes,
  output logic cmd_enable,
  output logic status_enable,
  output logic nv_prog,
  output logic nv_prog_sel512
);
  localparam fup_count_t ENTRY_LIMIT = fup_count_t'(`FUP_UDPD_ENTRY_CYC);
  localparam fup_count_t RECOVERY_LIMIT = fup_count_t'(EXIT_RECOVERY_CYC);
  localparam fup_count_t PROG_LIMIT = fup_count_t'(CONFIG_PROG_CYC);
  localparam logic [7:0] EXIT_LOW_LIMIT = 8'(`FUP_EXIT_LOW_CYC);

  fup_state_e state_reg;
  fup_state_e state_next;
  fup_count_t cnt_reg;
  logic cnt_done;
  logic cs_prev_reg;
  logic cs_rise;
  logic cs_fall;
  logic frame_ok_reg;
  logic status_ok_reg;
  logic udpd_hit_reg;
  logic cfg_ok_reg;
  logic cfg_hit_reg;
  logic cfg_sel512_reg;
  logic [7:0] low_cnt_reg;
  logic loaded_reg;
  logic power_down_reg;
  logic buffers_lost_reg;
  logic buffers_undefined_reg;
  logic rdy_busy_reg;
  logic size_sel512_reg;
  logic [9:0] page_bytes_reg;
  logic cmd_enable_reg;
  logic status_enable_reg;
  logic nv_prog_reg;
  logic nv_prog_sel512_reg;
  logic byte_strobe;
  fup_byte_t byte_data;
  logic [2:0] byte_idx;
  logic [2:0] bit_cnt;
  logic frame_end_ok;

  fup_shifter u_shifter (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .byte_strobe(byte_strobe),
    .byte_data(byte_data),
    .byte_idx(byte_idx),
    .bit_cnt(bit_cnt)
  );

  assign cs_rise = cs_n & ~cs_prev_reg;
  assign cs_fall = ~cs_n & cs_prev_reg;
  assign frame_end_ok = cs_rise && frame_ok_reg && (bit_cnt == 3'h0);

  // Select edges are found against the idle-high level, so reset makes no false edge.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      cs_prev_reg <= 1'b1;
    else
      cs_prev_reg <= cs_n;
  end

  // Only frames that begin in standby are decoded.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      frame_ok_reg <= 1'b0;
    else if (cs_fall)
      frame_ok_reg <= (state_reg == ST_STANDBY);
  end

  // Status reads stay open for frames that begin in standby or while programming.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      status_ok_reg <= 1'b0;
    else if (cs_fall)
      status_ok_reg <= (state_reg == ST_STANDBY || state_reg == ST_PROG);
  end

  // Opcode decode; bytes past the ones of interest are dropped.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || cs_fall)
    begin
      udpd_hit_reg <= 1'b0;
      cfg_ok_reg <= 1'b0;
      cfg_hit_reg <= 1'b0;
      cfg_sel512_reg <= 1'b0;
    end
    else if (byte_strobe)
    begin
      unique case (byte_idx)
        3'h0:
        begin
          udpd_hit_reg <= (byte_data == `FUP_OP_UDPD_ENTER);
          cfg_ok_reg <= (byte_data == `FUP_OP_CFG_B0);
        end
        3'h1:
          cfg_ok_reg <= cfg_ok_reg && (byte_data == `FUP_OP_CFG_B1);
        3'h2:
          cfg_ok_reg <= cfg_ok_reg && (byte_data == `FUP_OP_CFG_B2);
        3'h3:
        begin
          cfg_hit_reg <= cfg_ok_reg &&
            (byte_data == `FUP_OP_CFG_512 || byte_data == `FUP_OP_CFG_528);
          cfg_sel512_reg <= (byte_data == `FUP_OP_CFG_512);
        end
        default:
        begin
          cfg_ok_reg <= cfg_ok_reg;
        end
      endcase
    end
  end

  // Wake pulse length is measured only in power-down; clocked data is not looked at.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || cs_n || state_reg != ST_UDPD)
      low_cnt_reg <= 8'h00;
    else if (low_cnt_reg != 8'hff)
      low_cnt_reg <= low_cnt_reg + 8'h01;
  end

  // Each timed state ends when the shared counter reaches one less than its limit.
  assign cnt_done = (state_reg == ST_ENTER && cnt_reg >= ENTRY_LIMIT - 22'h1) ||
    (state_reg == ST_EXIT && cnt_reg >= RECOVERY_LIMIT - 22'h1) ||
    (state_reg == ST_PROG && cnt_reg >= PROG_LIMIT - 22'h1);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_STANDBY:
      begin
        if (frame_end_ok && !op_busy && udpd_hit_reg)
          state_next = ST_ENTER;
        else if (frame_end_ok && !op_busy && cfg_hit_reg)
          state_next = ST_PROG;
      end
      ST_ENTER:
      begin
        if (cnt_done)
          state_next = ST_UDPD;
      end
      ST_UDPD:
      begin
        if (cs_rise && low_cnt_reg >= EXIT_LOW_LIMIT)
          state_next = ST_EXIT;
      end
      ST_EXIT:
      begin
        if (cnt_done)
          state_next = ST_STANDBY;
      end
      ST_PROG:
      begin
        if (cnt_done)
          state_next = ST_STANDBY;
      end
      default:
        state_next = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      state_reg <= ST_STANDBY;
    else
      state_reg <= state_next;
  end

  // The shared counter restarts on every state change.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || state_next != state_reg)
      cnt_reg <= 22'h0;
    else if (!cnt_done)
      cnt_reg <= cnt_reg + 22'h1;
  end

  // Size comes from the nonvolatile cell one cycle after reset release.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      loaded_reg <= 1'b0;
      size_sel512_reg <= `FUP_SEL512_DEFAULT;
    end
    else if (!loaded_reg)
    begin
      loaded_reg <= 1'b1;
      size_sel512_reg <= nv_sel512;
    end
    else if (state_reg == ST_PROG && cnt_done)
      size_sel512_reg <= nv_prog_sel512_reg;
  end

  // Page size follows the size flag at every point where the flag changes.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      page_bytes_reg <= `FUP_PAGE_BINARY + `FUP_PAGE_EXTRA;
    else if (state_reg == ST_PROG && cnt_done && nv_prog_sel512_reg)
      page_bytes_reg <= `FUP_PAGE_BINARY;
    else if (state_reg == ST_PROG && cnt_done)
      page_bytes_reg <= `FUP_PAGE_BINARY + `FUP_PAGE_EXTRA;
    else if (!loaded_reg)
      page_bytes_reg <= nv_sel512 ? `FUP_PAGE_BINARY : `FUP_PAGE_BINARY + `FUP_PAGE_EXTRA;
  end

  // The value to program is latched at the frame end that starts programming.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      nv_prog_reg <= 1'b0;
      nv_prog_sel512_reg <= 1'b0;
    end
    else
    begin
      nv_prog_reg <= (state_next == ST_PROG);
      if (state_reg == ST_STANDBY && state_next == ST_PROG)
        nv_prog_sel512_reg <= cfg_sel512_reg;
    end
  end

  // Power-down and the buffer loss pulse follow the next state.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      power_down_reg <= 1'b0;
      buffers_lost_reg <= 1'b0;
    end
    else
    begin
      power_down_reg <= (state_next == ST_UDPD);
      buffers_lost_reg <= (state_reg == ST_ENTER && state_next == ST_UDPD);
    end
  end

  // Buffers stay flagged undefined until the next frame accepted in standby.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      buffers_undefined_reg <= 1'b0;
    else if (state_next == ST_UDPD)
      buffers_undefined_reg <= 1'b1;
    else if (cs_fall && state_reg == ST_STANDBY)
      buffers_undefined_reg <= 1'b0;
  end

  // Ready drops for size programming and for any other self-timed operation.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      rdy_busy_reg <= 1'b1;
    else
      rdy_busy_reg <= (state_next != ST_PROG) && !op_busy;
  end

  // Commands need a frame begun in standby; status reads also pass during programming.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      cmd_enable_reg <= 1'b0;
      status_enable_reg <= 1'b0;
    end
    else
    begin
      cmd_enable_reg <= (state_next == ST_STANDBY) &&
        (cs_n || (frame_ok_reg && !cs_fall) || (cs_fall && state_reg == ST_STANDBY));
      status_enable_reg <= (state_next == ST_STANDBY || state_next == ST_PROG) &&
        (cs_n || (status_ok_reg && !cs_fall) ||
        (cs_fall && (state_reg == ST_STANDBY || state_reg == ST_PROG)));
    end
  end

  assign power_down = power_down_reg;
  assign buffers_lost = buffers_lost_reg;
  assign buffers_undefined = buffers_undefined_reg;
  assign rdy_busy = rdy_busy_reg;
  assign size_sel512 = size_sel512_reg;
  assign page_bytes = page_bytes_reg;
  assign cmd_enable = cmd_enable_reg;
  assign status_enable = status_enable_reg;
  assign nv_prog = nv_prog_reg;
  assign nv_prog_sel512 = nv_prog_sel512_reg;
endmodule : fup_power_cfg
`default_nettype wire

// File: fup_power_cfg_checker.sv
`default_nettype none
module fup_power_cfg_checker
#(
  parameter int unsigned EXIT_RECOVERY_CYC = 20,
  parameter int unsigned CONFIG_PROG_CYC = 30
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic power_down,
  input wire logic buffers_lost,
  input wire logic buffers_undefined,
  input wire logic rdy_busy,
  input wire logic size_sel512,
  input wire logic [9:0] page_bytes,
  input wire logic cmd_enable,
  input wire logic status_enable,
  input wire logic nv_prog,
  input wire logic nv_prog_sel512
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REC_MAX = EXIT_RECOVERY_CYC + 8;
  int prog_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Counts the cycles for which the size cell has been programmed.
  always_ff @(posedge clk_sys)
    prog_cnt <= (!resetn || !nv_prog) ? 0 : prog_cnt + 1;
  a_lost_on_entry: assert property (
    $rose(power_down) |-> buffers_lost && buffers_undefined)
    else $error("buffers not dropped at power-down");
  a_pd_deaf: assert property (power_down |-> !cmd_enable && !status_enable)
    else $error("commands enabled in power-down");
  a_pd_holds: assert property (
    power_down && cs_n && $past(cs_n) && $past(cs_n, 2) |=> power_down)
    else $error("power-down left without a pulse");
  a_wake_exit: assert property (
    $fell(power_down) |-> !cmd_enable [*8] ##[1:REC_MAX] status_enable)
    else $error("recovery time wrong");
  a_busy_prog: assert property (nv_prog |-> !rdy_busy && !cmd_enable)
    else $error("ready while programming");
  a_prog_status: assert property (nv_prog |-> status_enable)
    else $error("status blocked while programming");
  a_prog_bound: assert property (prog_cnt <= CONFIG_PROG_CYC + 1)
    else $error("programming too long");
  a_size_apply: assert property (
    $fell(nv_prog) |-> size_sel512 == $past(nv_prog_sel512))
    else $error("new size not applied");
  a_size_hold: assert property (
    $past(resetn, 3) && $past(resetn, 2) && !$past(nv_prog) |-> $stable(size_sel512))
    else $error("size changed without programming");
  a_page_count: assert property (page_bytes == (size_sel512 ? 10'h200 : 10'h210))
    else $error("page size mismatch");
  c_enter: cover property ($rose(power_down));
  c_wake: cover property ($fell(power_down));
  c_prog: cover property ($fell(nv_prog));
endmodule : fup_power_cfg_checker
bind fup_power_cfg fup_power_cfg_checker #(.EXIT_RECOVERY_CYC(EXIT_RECOVERY_CYC),
  .CONFIG_PROG_CYC(CONFIG_PROG_CYC)) chk_i (.clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n),
  .power_down(power_down), .buffers_lost(buffers_lost), .buffers_undefined(buffers_undefined),
  .rdy_busy(rdy_busy), .size_sel512(size_sel512), .page_bytes(page_bytes),
  .cmd_enable(cmd_enable), .status_enable(status_enable), .nv_prog(nv_prog),
  .nv_prog_sel512(nv_prog_sel512));
`default_nettype wire

// File: fup_host.sv
`default_nettype none
module fup_host
(
  input wire logic clk_sys,
  output logic cs_n,
  output logic sck,
  output logic si
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Sends n bits of d, first bit first; bits past the word go out as zero.
  task automatic send(input logic [31:0] d, input int n);
    int i;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      si <= (i < 32) ? d[31 - i] : 1'b0;
      sck <= 1'b0;
      @(posedge clk_sys);
      sck <= 1'b1;
    end
    @(posedge clk_sys);
    sck <= 1'b0;
    @(posedge clk_sys);
    cs_n <= 1'b1;
    si <= ~si;
  endtask : send
endmodule : fup_host
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
  import fup_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic op_busy = 1'b0;
  logic nv_sel512 = 1'b0;
  logic cs_n, sck, si, power_down, buffers_lost, buffers_undefined, rdy_busy, size_sel512;
  logic cmd_enable, status_enable, nv_prog, nv_prog_sel512;
  logic [9:0] page_bytes;
  int err_total = 0;
  int check_count = 0;
  fup_host fup_host_i (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si));
  fup_power_cfg #(.EXIT_RECOVERY_CYC(20), .CONFIG_PROG_CYC(30)) fup_power_cfg_i (
    .clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si), .op_busy(op_busy),
    .nv_sel512(nv_sel512), .power_down(power_down), .buffers_lost(buffers_lost),
    .buffers_undefined(buffers_undefined), .rdy_busy(rdy_busy), .size_sel512(size_sel512),
    .page_bytes(page_bytes), .cmd_enable(cmd_enable), .status_enable(status_enable),
    .nv_prog(nv_prog), .nv_prog_sel512(nv_prog_sel512));
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  // Nonvolatile cell takes the size being programmed and keeps it across resets.
  always @(posedge clk_sys)
  begin
    if (nv_prog)
      nv_sel512 <= nv_prog_sel512;
  end
  task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t %s", $time, what);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic t_size(input logic sel);
    fup_host_i.send({24'h3d2a80, 7'h53, sel ? 1'b0 : 1'b1}, 32);
    cyc(2);
    check(nv_prog, 1'b1, "no programming");
    check(rdy_busy, 1'b0, "not busy");
    check(nv_prog_sel512, sel, "programmed value");
    check(status_enable, 1'b1, "status blocked");
    fork
      fup_host_i.send(32'h79000000, 8);
      begin
        cyc(10);
        check(status_enable, 1'b1, "status blocked in frame");
        check(cmd_enable, 1'b0, "command open in frame");
      end
    join
    cyc(170);
    check(power_down, 1'b0, "entry taken while busy");
    check(size_sel512, sel, "size flag");
    check(page_bytes, sel ? 10'h200 : 10'h210, "page bytes");
    check(rdy_busy, 1'b1, "still busy");
    $display("size test done");
  endtask : t_size
  task automatic t_abort();
    fup_host_i.send(32'h3d2a80a6, 36);
    fup_host_i.send(32'h3d2a8000, 24);
    fup_host_i.send(32'h79000000, 4);
    fup_host_i.send(32'h79800000, 12);
    cyc(170);
    check(power_down, 1'b0, "aborted entry");
    check(size_sel512, 1'b0, "aborted size");
    @(posedge clk_sys);
    op_busy <= 1'b1;
    fup_host_i.send(32'h79000000, 8);
    cyc(3);
    check(rdy_busy, 1'b0, "ready during operation");
    cyc(170);
    check(power_down, 1'b0, "entry while busy");
    @(posedge clk_sys);
    op_busy <= 1'b0;
    $display("abort test done");
  endtask : t_abort
  task automatic t_udpd();
    fup_host_i.send(32'h79a50000, 16);
    cyc(160);
    check(power_down, 1'b1, "no power-down");
    check(buffers_undefined, 1'b1, "buffers kept");
    check(cmd_enable, 1'b0, "commands open");
    check(status_enable, 1'b0, "status open");
    fup_host_i.send(32'h3d2a80a6, 32);
    fup_host_i.send(32'h79000000, 8);
    cyc(3);
    check(nv_prog, 1'b0, "size taken in power-down");
    cyc(170);
    check(power_down, 1'b0, "no wake or frame taken");
    check(cmd_enable, 1'b1, "no standby");
    $display("power-down test done");
  endtask : t_udpd
  task automatic t_power();
    fup_host_i.send(32'h79000000, 8);
    cyc(160);
    check(power_down, 1'b1, "not down before power cycle");
    @(posedge clk_sys);
    resetn <= 1'b0;
    cyc(8);
    resetn <= 1'b1;
    cyc(3);
    check(power_down, 1'b0, "power-up state");
    check(size_sel512, 1'b1, "size lost");
    $display("power cycle test done");
  endtask : t_power
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
  initial
  begin
    cyc(8);
    resetn <= 1'b1;
    cyc(3);
    check(power_down, 1'b0, "boot state");
    check(page_bytes, 10'h210, "default size");
    t_size(1'b1);
    t_size(1'b0);
    t_abort();
    t_udpd();
    t_size(1'b1);
    t_power();
    summarize();
  end
endmodule : tb
`default_nettype wire
